/* rtl/dsef_pkg.sv */
// types for the disk sense flag block
package dsef_pkg;
  typedef struct packed {
    logic index_point;
    logic address_marker;
    logic count_field;
    logic count_flag_bit0;
    logic count_check;
    logic data_field_xfer;
    logic ha_r0_read;
    logic ha_r0_not_found;
    logic cylinder_end;
    logic ha_compare_fail;
    logic head_switched;
  } dsef_drive_type;
  typedef struct packed {
    logic valid;
    logic [3:0] code;
    logic multitrack;
    logic chained;
  } dsef_cmd_type;
endpackage

/* rtl/dsef_regs.svh */
// sense bit positions and command codes for the disk sense flag block
`ifndef DSEF_REGS_SVH
`define DSEF_REGS_SVH
`define DSEF_S0_CMD_REJECT 0
`define DSEF_S0_EQUIP_CHECK 3
`define DSEF_S0_DATA_CHECK 4
`define DSEF_S0_SEEK_CHECK 7
`define DSEF_S1_COUNT_CHECK 0
`define DSEF_S1_TRACK_OVERRUN 1
`define DSEF_S1_END_CYL 2
`define DSEF_S1_NO_RECORD 4
`define DSEF_S1_FILE_PROTECT 5
`define DSEF_S1_MISSING_AM 6
`define DSEF_SENSE_RESET 8'h00
`define DSEF_CMD_SEEK 4'h1
`define DSEF_CMD_READ 4'h2
`define DSEF_CMD_WRITE 4'h3
`define DSEF_CMD_SEARCH 4'h4
`define DSEF_CMD_READ_HA 4'h5
`define DSEF_CMD_READ_R0 4'h6
`define DSEF_CMD_NOP 4'h0
`endif

/* rtl/dsef_sense.sv */
// sense flag logic of the disk attachment
// How it works
// - index point during an unfinished write sets track overrun, byte one bit 1
// - multitrack chain reaching cylinder end sets end of cylinder, byte one bit 2
// - two index points without data or home address transfer set no record found
// - seek, multitrack read or search against the seek mask sets file protect
// - count field check sets byte one bit 0 and byte zero data check
// - home address or record zero not found sets no record and missing marker
// - failed home address compare after multitrack head switch reports equipment check
// - two index points without marker, or equal count flag bits, set missing marker
// - unrecognised command code sets command reject, byte zero bit 0
`timescale 1ns/1ps
`include "dsef_regs.svh"
module dsef_sense (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire dsef_pkg::dsef_cmd_type i_cmd,
  input wire logic i_write_active,
  input wire logic i_seek_permit,
  input wire logic i_chain_done,
  input wire logic i_sense_read,
  input wire dsef_pkg::dsef_drive_type i_drive,
  output logic [7:0] o_sense0,
  output logic [7:0] o_sense1
);
  import dsef_pkg::*;

  function automatic logic known_code(input logic [3:0] c);
    known_code = (c <= `DSEF_CMD_READ_R0);
  endfunction

  dsef_drive_type drv_m_q;
  dsef_drive_type drv_q;
  logic [7:0] s0_q;
  logic [7:0] s0_d;
  logic [7:0] s1_q;
  logic [7:0] s1_d;
  logic in_chain_q;
  logic idx_nr_q;
  logic idx_am_q;
  logic flag_seen_q;
  logic flag_last_q;
  logic [7:0] set0;
  logic [7:0] set1;

  wire new_cmd = i_cmd.valid;
  wire clear_all = i_sense_read | new_cmd;
  wire cmd_bad = new_cmd && !known_code(i_cmd.code);
  wire is_seek = i_cmd.code == `DSEF_CMD_SEEK;
  wire is_mt_rs = i_cmd.multitrack
    && (i_cmd.code == `DSEF_CMD_READ || i_cmd.code == `DSEF_CMD_SEARCH);
  wire protect_hit = new_cmd && (is_seek || is_mt_rs) && !i_seek_permit;
  wire xfer_seen = drv_q.data_field_xfer | drv_q.ha_r0_read;
  wire nr_hit = in_chain_q && drv_q.index_point && idx_nr_q && !xfer_seen;
  wire am_idx_hit = drv_q.index_point && idx_am_q && !drv_q.address_marker;
  wire am_flag_hit = drv_q.count_field && flag_seen_q
    && (drv_q.count_flag_bit0 == flag_last_q);
  wire ha_missing = drv_q.ha_r0_not_found;
  wire mt_active = in_chain_q && i_cmd.multitrack;

  always_comb
  begin
    set0 = 8'h00;
    set1 = 8'h00;
    set0[`DSEF_S0_CMD_REJECT] = cmd_bad;
    set1[`DSEF_S1_COUNT_CHECK] = drv_q.count_check;
    set0[`DSEF_S0_DATA_CHECK] = drv_q.count_check;
    set1[`DSEF_S1_TRACK_OVERRUN] = drv_q.index_point && i_write_active;
    set1[`DSEF_S1_END_CYL] = drv_q.cylinder_end && mt_active && !i_chain_done;
    set1[`DSEF_S1_NO_RECORD] = nr_hit || ha_missing;
    set1[`DSEF_S1_FILE_PROTECT] = protect_hit;
    set1[`DSEF_S1_MISSING_AM] = ha_missing || am_idx_hit || am_flag_hit;
    set0[`DSEF_S0_EQUIP_CHECK] = drv_q.ha_compare_fail && drv_q.head_switched
      && mt_active;
    set0[`DSEF_S0_SEEK_CHECK] = set0[`DSEF_S0_EQUIP_CHECK];
  end

  assign s0_d = (clear_all ? `DSEF_SENSE_RESET : s0_q) | set0;
  assign s1_d = (clear_all ? `DSEF_SENSE_RESET : s1_q) | set1;

  always_ff @(posedge i_clk)
  begin
    drv_m_q <= i_drive;
    drv_q <= drv_m_q;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      s0_q <= `DSEF_SENSE_RESET;
      s1_q <= `DSEF_SENSE_RESET;
    end
    else
    begin
      s0_q <= s0_d;
      s1_q <= s1_d;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      in_chain_q <= 1'b0;
      idx_nr_q <= 1'b0;
    end
    else
    begin
      if (new_cmd)
        in_chain_q <= 1'b1;
      else if (i_chain_done)
        in_chain_q <= 1'b0;
      if (new_cmd && !i_cmd.chained)
        idx_nr_q <= 1'b0;
      else if (xfer_seen || nr_hit)
        idx_nr_q <= 1'b0;
      else if (drv_q.index_point && in_chain_q)
        idx_nr_q <= 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      idx_am_q <= 1'b0;
      flag_seen_q <= 1'b0;
      flag_last_q <= 1'b0;
    end
    else
    begin
      if (drv_q.address_marker)
        idx_am_q <= 1'b0;
      else if (drv_q.index_point)
        idx_am_q <= 1'b1;
      if (drv_q.count_field)
      begin
        flag_seen_q <= 1'b1;
        flag_last_q <= drv_q.count_flag_bit0;
      end
    end
  end

  assign o_sense0 = s0_q;
  assign o_sense1 = s1_q;

  count_check_a: assert property (@(posedge i_clk) disable iff (i_rst)
    drv_q.count_check |=> s0_q[`DSEF_S0_DATA_CHECK] && s1_q[`DSEF_S1_COUNT_CHECK])
    else $error("count check did not set both flags");
  track_overrun_a: assert property (@(posedge i_clk) disable iff (i_rst)
    drv_q.index_point && i_write_active |=> s1_q[`DSEF_S1_TRACK_OVERRUN])
    else $error("track overrun not set");
  end_cyl_a: assert property (@(posedge i_clk) disable iff (i_rst)
    drv_q.cylinder_end && mt_active && !i_chain_done |=> s1_q[`DSEF_S1_END_CYL])
    else $error("end of cylinder not set");
  no_record_a: assert property (@(posedge i_clk) disable iff (i_rst)
    nr_hit && !ha_missing && !am_idx_hit && !am_flag_hit && !s1_q[`DSEF_S1_MISSING_AM]
    |=> s1_q[`DSEF_S1_NO_RECORD] && !s1_q[`DSEF_S1_MISSING_AM])
    else $error("no record found wrong");
  file_protect_a: assert property (@(posedge i_clk) disable iff (i_rst)
    protect_hit |=> s1_q[`DSEF_S1_FILE_PROTECT])
    else $error("file protect not set");
  permit_ok_a: assert property (@(posedge i_clk) disable iff (i_rst)
    new_cmd && i_seek_permit |=> !s1_q[`DSEF_S1_FILE_PROTECT])
    else $error("file protect set although permitted");
  ha_missing_a: assert property (@(posedge i_clk) disable iff (i_rst)
    ha_missing |=> s1_q[`DSEF_S1_NO_RECORD] && s1_q[`DSEF_S1_MISSING_AM])
    else $error("missing home address flags wrong");
  head_switch_a: assert property (@(posedge i_clk) disable iff (i_rst)
    drv_q.ha_compare_fail && drv_q.head_switched && mt_active
    |=> s0_q[`DSEF_S0_EQUIP_CHECK])
    else $error("equipment check not set");
  marker_a: assert property (@(posedge i_clk) disable iff (i_rst)
    am_idx_hit || am_flag_hit |=> s1_q[`DSEF_S1_MISSING_AM])
    else $error("missing marker not set");
  cmd_reject_a: assert property (@(posedge i_clk) disable iff (i_rst)
    cmd_bad |=> s0_q[`DSEF_S0_CMD_REJECT])
    else $error("command reject not set");
  known_cmd_a: assert property (@(posedge i_clk) disable iff (i_rst)
    new_cmd && !cmd_bad |=> !s0_q[`DSEF_S0_CMD_REJECT])
    else $error("command reject set for known code");
  sticky_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !clear_all && set1 == 8'h00 |=> s1_q == $past(s1_q))
    else $error("sense byte changed without cause");
  sense_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
    clear_all && set0 == 8'h00 && set1 == 8'h00
    |=> s0_q == `DSEF_SENSE_RESET && s1_q == `DSEF_SENSE_RESET)
    else $error("sense bytes not cleared");
  reset_clear_a: assert property (@(posedge i_clk)
    i_rst |=> s0_q == `DSEF_SENSE_RESET && s1_q == `DSEF_SENSE_RESET)
    else $error("sense bytes not cleared by reset");

  cover property (@(posedge i_clk) disable iff (i_rst) nr_hit);
  cover property (@(posedge i_clk) disable iff (i_rst) am_flag_hit);
  cover property (@(posedge i_clk) disable iff (i_rst) protect_hit ##1 i_sense_read);
  cover property (@(posedge i_clk) disable iff (i_rst) am_idx_hit);
  cover property (@(posedge i_clk) disable iff (i_rst)
    drv_q.ha_compare_fail && drv_q.head_switched && mt_active);
endmodule // dsef_sense

/* verification/disk_sense_error_flags_test.sv */
// self-checking bench for the disk sense flag block
`timescale 1ns/1ps
`include "dsef_regs.svh"
module disk_sense_error_flags_test;
  import dsef_pkg::*;
  localparam logic [10:0] idx = 11'h400, am = 11'h200, cf = 11'h180, cc = 11'h040;
  localparam logic [10:0] nf = 11'h008, ce = 11'h004, hcf = 11'h002, hs = 11'h001;
  logic i_clk = 0, i_rst = 1, wr = 0, permit = 1, done = 0, rd = 0, go = 0;
  logic [10:0] ev = '0;
  logic [4:0] fp [3] = '{{`DSEF_CMD_SEEK, 1'b0}, {`DSEF_CMD_READ, 1'b1}, {`DSEF_CMD_SEARCH, 1'b1}};
  dsef_cmd_type cmd = '0;
  dsef_drive_type drv;
  logic [7:0] s0, s1;
  int n_fail = 0;
  int compares = 0;
  int seed = 32'h3322;
  initial
  begin
    forever #50 i_clk = ~i_clk;
  end
  dsef_drive_model i_drv (.i_go(go), .i_ev(ev), .o_drive(drv));
  dsef_sense i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_cmd(cmd), .i_write_active(wr),
    .i_seek_permit(permit), .i_chain_done(done), .i_sense_read(rd), .i_drive(drv),
    .o_sense0(s0), .o_sense1(s1));
  function automatic logic [7:0] bm(input int p);
    return 8'h01 << p;
  endfunction
  task automatic print_verdict();
    if (n_fail == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] e0, input logic [7:0] e1, input logic [7:0] m1);
    compares++;
    if (s0 !== e0 || (s1 & m1) !== e1)
    begin
      n_fail++;
      $display("MISMATCH %0t exp %h %h got %h %h", $time, e0, e1, s0, s1);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  task automatic clr();
    rd = 1;
    tick(1);
    rd = 0;
    tick(1);
    chk(8'h00, 8'h00, 8'hFF);
  endtask
  task automatic send(input logic [3:0] c, input logic mt, input logic ch);
    cmd = '{1'b1, c, mt, ch};
    tick(1);
    cmd.valid = 0;
    tick(1);
  endtask
  task automatic pulse(input logic [10:0] m);
    ev = m;
    go = 1;
    tick(1);
    go = 0;
    tick(5);
  endtask
  initial
  begin
    logic [3:0] c;
    tick(8);
    i_rst = 0;
    chk(8'h00, 8'h00, 8'hFF);
    for (int k = 0; k < 4; k++)
    begin
      c = (k == 0) ? 4'hF : 4'h7 + 4'($unsigned($random(seed)) % 9);
      send(c, 0, 0);
      chk(bm(`DSEF_S0_CMD_REJECT), 8'h00, 8'hFF);
      clr();
    end
    permit = 0;
    foreach (fp[k])
    begin
      send(fp[k][4:1], fp[k][0], 0);
      chk(8'h00, bm(`DSEF_S1_FILE_PROTECT), 8'hFF);
      clr();
    end
    permit = 1;
    send(`DSEF_CMD_READ, 0, 0);
    pulse(cc);
    chk(bm(`DSEF_S0_DATA_CHECK), bm(`DSEF_S1_COUNT_CHECK), 8'hFF);
    clr();
    pulse(nf);
    chk(8'h00, bm(`DSEF_S1_NO_RECORD) | bm(`DSEF_S1_MISSING_AM), 8'hFF);
    clr();
    wr = 1;
    pulse(am);
    pulse(idx);
    wr = 0;
    chk(8'h00, bm(`DSEF_S1_TRACK_OVERRUN), 8'hFF);
    send(`DSEF_CMD_READ, 1, 1);
    pulse(ce);
    chk(8'h00, bm(`DSEF_S1_END_CYL), 8'hFF);
    clr();
    pulse(hs);
    chk(8'h00, 8'h00, 8'hFF);
    pulse(hs | hcf);
    chk(bm(`DSEF_S0_EQUIP_CHECK) | bm(`DSEF_S0_SEEK_CHECK), 8'h00, 8'hFF);
    done = 1;
    pulse(ce);
    done = 0;
    chk(bm(`DSEF_S0_EQUIP_CHECK) | bm(`DSEF_S0_SEEK_CHECK), 8'h00, 8'hFF);
    send(`DSEF_CMD_READ, 0, 0);
    pulse(am);
    pulse(idx);
    chk(8'h00, 8'h00, 8'h10);
    pulse(am);
    pulse(idx);
    chk(8'h00, bm(`DSEF_S1_NO_RECORD), 8'h50);
    clr();
    pulse(idx);
    pulse(11'h020);
    pulse(idx);
    chk(8'h00, 8'h00, 8'h10);
    clr();
    pulse(cf);
    pulse(cf);
    chk(8'h00, bm(`DSEF_S1_MISSING_AM), 8'h40);
    clr();
    pulse(11'h100);
    chk(8'h00, 8'h00, 8'h40);
    pulse(am);
    pulse(idx);
    pulse(idx);
    chk(8'h00, bm(`DSEF_S1_MISSING_AM), 8'h40);
    i_rst = 1;
    tick(3);
    i_rst = 0;
    chk(8'h00, 8'h00, 8'hFF);
    pulse(nf);
    send(`DSEF_CMD_NOP, 0, 0);
    chk(8'h00, 8'h00, 8'hFF);
    print_verdict();
  end
  initial
  begin
    #(2000 * 100);
    n_fail++;
    print_verdict();
  end
endmodule // disk_sense_error_flags_test

/* verification/dsef_drive_model.sv */
// disk drive model driving event pulses into the sense block
`timescale 1ns/1ps
module dsef_drive_model (
  input wire logic i_go,
  input wire logic [10:0] i_ev,
  output dsef_pkg::dsef_drive_type o_drive
);
  import dsef_pkg::*;
  // idle lines return low outside a pulse
  assign o_drive = i_go ? dsef_drive_type'(i_ev) : '0;
endmodule // dsef_drive_model
